//--- verilog/udst_params.svh
// constants for the device state tracker
`ifndef UDST_PARAMS_SVH
`define UDST_PARAMS_SVH

`define UDST_CLK_KHZ          200000
`define UDST_IDLE_MS          3
`define UDST_IDLE_CYC         (`UDST_IDLE_MS * `UDST_CLK_KHZ)
`define UDST_ADDR_W           7
`define UDST_DEF_ADDR         7'h00
`define UDST_CFG_W            8
`define UDST_CFG_NONE         8'h00
`define UDST_BUS_MA_LIMIT     100
`define UDST_IDLE_CNT_W       20

`endif

//--- verilog/udst_pkg.sv
// types for the device state tracker
package udst_pkg;

typedef enum logic [2:0]
{
    UDST_ATTACHED,
    UDST_POWERED,
    UDST_DEFAULT,
    UDST_ADDRESS,
    UDST_CONFIGURED
} udst_state_t;

endpackage : udst_pkg

//--- verilog/udst_sync.sv
// two-flop synchroniser for one pin
module udst_sync
(
    input  wire logic i_ref_clk,
    input  wire logic i_nrst,
    input  wire logic i_pin,
    output logic      o_sync
);

typedef struct packed
{
    logic s1;
    logic s2;
} udst_sync_t;

udst_sync_t q_r;
udst_sync_t q_nxt;

always_comb
begin
    q_nxt.s1 = i_pin;
    q_nxt.s2 = q_r.s1;
end

always_ff @(posedge i_ref_clk)
begin
    if (!i_nrst)
    begin
        q_r <= '0;
    end
    else
    begin
        q_r <= q_nxt;
    end
end

assign o_sync = q_r.s2;

endmodule : udst_sync

//--- verilog/udst_tracker.sv
// device visible-state tracker: reset, address, configuration, suspend, power
`include "udst_params.svh"

module udst_tracker
    import udst_pkg::*;
#(
    parameter logic [`UDST_IDLE_CNT_W-1:0] IDLE_CYC = `UDST_IDLE_CNT_W'(`UDST_IDLE_CYC)
)
(
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_nrst,
    input  wire logic                    i_attached,
    input  wire logic                    i_vbus,
    input  wire logic                    i_bus_reset,
    input  wire logic                    i_bus_activity,
    input  wire logic                    i_hs_chirp_ok,
    input  wire logic                    i_self_powered,
    input  wire logic                    i_hs_capable,
    input  wire logic                    i_tok_valid,
    input  wire logic [`UDST_ADDR_W-1:0] i_tok_addr,
    input  wire logic                    i_set_addr,
    input  wire logic [`UDST_ADDR_W-1:0] i_set_addr_val,
    input  wire logic                    i_set_cfg,
    input  wire logic [`UDST_CFG_W-1:0]  i_set_cfg_val,
    input  wire logic                    i_cfg_one_mode,
    input  wire logic                    i_cfg_high_power,
    input  wire logic                    i_set_rwake,
    input  wire logic                    i_clr_rwake,
    output logic [2:0]                   o_state,
    output logic                         o_suspended,
    output logic                         o_in_reset,
    output logic                         o_tok_match,
    output logic [`UDST_ADDR_W-1:0]      o_dev_addr,
    output logic [`UDST_CFG_W-1:0]       o_cfg_val,
    output logic                         o_self_powered,
    output logic                         o_high_speed,
    output logic                         o_rwake_en,
    output logic                         o_ep_reset
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
logic att_s;
logic vbus_s;
logic rst_s;
logic act_s;
logic chirp_s;
logic selfp_s;

udst_sync u_sync_att
(
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_pin     (i_attached),
    .o_sync    (att_s)
);

udst_sync u_sync_vbus
(
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_pin     (i_vbus),
    .o_sync    (vbus_s)
);

udst_sync u_sync_rst
(
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_pin     (i_bus_reset),
    .o_sync    (rst_s)
);

udst_sync u_sync_act
(
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_pin     (i_bus_activity),
    .o_sync    (act_s)
);

udst_sync u_sync_chirp
(
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_pin     (i_hs_chirp_ok),
    .o_sync    (chirp_s)
);

udst_sync u_sync_selfp
(
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_pin     (i_self_powered),
    .o_sync    (selfp_s)
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
typedef struct packed
{
    udst_state_t                 state;
    logic                        susp;
    logic                        in_rst;
    logic                        hs_seen;
    logic                        hs;
    logic [`UDST_IDLE_CNT_W-1:0] idle_cnt;
    logic [`UDST_ADDR_W-1:0]     addr;
    logic [`UDST_CFG_W-1:0]      cfg;
    logic                        selfp;
    logic                        selfp_known;
    logic                        rwake;
    logic                        ep_rst;
    logic                        tok_match;
} udst_regs_t;

udst_regs_t q_r;
udst_regs_t q_nxt;

logic powered_ok;
logic src_change;
logic reset_done;

assign powered_ok = att_s & vbus_s;
assign src_change = q_r.selfp_known & (selfp_s != q_r.selfp);
assign reset_done = q_r.in_rst & ~rst_s;

// ----------------------------------------------------------------
// next-state logic
// ----------------------------------------------------------------
always_comb
begin
    q_nxt           = q_r;
    q_nxt.ep_rst    = 1'b0;
    q_nxt.tok_match = 1'b0;

    // power source status follows the pin at all times
    q_nxt.selfp       = selfp_s;
    q_nxt.selfp_known = 1'b1;

    if (!powered_ok)
    begin
        q_nxt.state    = UDST_ATTACHED;
        q_nxt.susp     = 1'b0;
        q_nxt.in_rst   = 1'b0;
        q_nxt.hs_seen  = 1'b0;
        q_nxt.hs       = 1'b0;
        q_nxt.idle_cnt = '0;
        q_nxt.addr     = `UDST_DEF_ADDR;
        q_nxt.cfg      = `UDST_CFG_NONE;
        q_nxt.rwake    = 1'b0;
    end
    else if (rst_s)
    begin
        // reset signaling in progress; high-speed handshake sampled here
        q_nxt.in_rst   = 1'b1;
        q_nxt.susp     = 1'b0;
        q_nxt.idle_cnt = '0;
        q_nxt.rwake    = 1'b0;
        if (i_hs_capable && chirp_s)
        begin
            q_nxt.hs_seen = 1'b1;
        end
        if (q_r.state == UDST_ATTACHED)
        begin
            q_nxt.state = UDST_POWERED;
        end
    end
    else if (reset_done)
    begin
        q_nxt.in_rst  = 1'b0;
        q_nxt.state   = UDST_DEFAULT;
        q_nxt.addr    = `UDST_DEF_ADDR;
        q_nxt.cfg     = `UDST_CFG_NONE;
        // no chirp means full speed, still a complete reset
        q_nxt.hs      = q_r.hs_seen;
        q_nxt.hs_seen = 1'b0;
    end
    else
    begin
        if (q_r.state == UDST_ATTACHED)
        begin
            q_nxt.state = UDST_POWERED;
        end

        // inactivity timer; address untouched while suspended, state changed only by the power source drop below
        if (act_s)
        begin
            q_nxt.idle_cnt = '0;
            q_nxt.susp     = 1'b0;
        end
        else if (!q_r.susp)
        begin
            if (q_r.idle_cnt >= IDLE_CYC - 1'b1)
            begin
                q_nxt.susp = 1'b1;
            end
            else
            begin
                q_nxt.idle_cnt = q_r.idle_cnt + 1'b1;
            end
        end

        if (!q_r.susp && q_r.state != UDST_POWERED && q_r.state != UDST_ATTACHED)
        begin
            if (i_tok_valid)
            begin
                // default pipe answers at current address, default or assigned
                q_nxt.tok_match = (i_tok_addr == q_r.addr);
            end

            if (i_set_addr && q_r.state != UDST_CONFIGURED)
            begin
                q_nxt.addr  = i_set_addr_val;
                q_nxt.state = (i_set_addr_val == `UDST_DEF_ADDR) ? UDST_DEFAULT
                                                                 : UDST_ADDRESS;
            end
            else if (i_set_cfg && q_r.state != UDST_DEFAULT)
            begin
                q_nxt.cfg    = i_set_cfg_val;
                q_nxt.ep_rst = (i_set_cfg_val != `UDST_CFG_NONE);
                q_nxt.state  = (i_set_cfg_val != `UDST_CFG_NONE) ? UDST_CONFIGURED
                                                                 : UDST_ADDRESS;
            end

            if (i_set_rwake)
            begin
                q_nxt.rwake = 1'b1;
            end
            else if (i_clr_rwake)
            begin
                q_nxt.rwake = 1'b0;
            end
        end

        // power source change drops a configuration that cannot follow
        if (src_change && q_r.state == UDST_CONFIGURED)
        begin
            if (i_cfg_one_mode || (i_cfg_high_power && !selfp_s))
            begin
                q_nxt.cfg   = `UDST_CFG_NONE;
                q_nxt.state = UDST_ADDRESS;
                // no endpoint reset for a dropped configuration
                q_nxt.ep_rst = 1'b0;
            end
        end
    end
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
always_ff @(posedge i_ref_clk)
begin
    if (!i_nrst)
    begin
        q_r       <= '0;
        q_r.state <= UDST_ATTACHED;
        q_r.addr  <= `UDST_DEF_ADDR;
        q_r.cfg   <= `UDST_CFG_NONE;
    end
    else
    begin
        q_r <= q_nxt;
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign o_state        = q_r.state;
assign o_suspended    = q_r.susp;
assign o_in_reset     = q_r.in_rst;
assign o_tok_match    = q_r.tok_match;
assign o_dev_addr     = q_r.addr;
assign o_cfg_val      = q_r.cfg;
assign o_self_powered = q_r.selfp;
assign o_high_speed   = q_r.hs;
assign o_rwake_en     = q_r.rwake;
assign o_ep_reset     = q_r.ep_rst;

endmodule : udst_tracker

//--- test/udst_host_model.sv
// host seen through the hub: bus reset, keep-alive traffic, address grants
module udst_host_model
(
    input  wire logic i_ref_clk,
    input  wire logic i_quiet,
    output logic      o_bus_reset,
    output logic      o_activity,
    output logic      o_set_addr,
    output logic [6:0] o_addr_val
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] tick = 4'h0;
    logic [6:0] grant = 7'h05;
    initial o_bus_reset = 1'b0;
    initial o_set_addr = 1'b0;
    initial o_addr_val = 7'h7f;
    initial o_activity = 1'b0;
    // keep-alive traffic well inside the idle window
    always @(negedge i_ref_clk)
    begin
        tick <= tick + 4'h1;
        o_activity <= !i_quiet && tick == 4'h0;
    end
    task automatic drive_reset(input int n);
        @(negedge i_ref_clk);
        o_bus_reset = 1'b1;
        repeat (n) @(negedge i_ref_clk);
        o_bus_reset = 1'b0;
    endtask : drive_reset
    task automatic assign_addr(output logic [6:0] a);
        @(negedge i_ref_clk);
        o_set_addr = 1'b1;
        o_addr_val = grant;
        a = grant;
        @(negedge i_ref_clk);
        o_set_addr = 1'b0;
        o_addr_val = ~grant;
        grant = grant + 7'h01;
    endtask : assign_addr
endmodule : udst_host_model

//--- test/udst_tracker_asserts.sv
// concurrent checks on the device state tracker ports
module udst_tracker_chk
(
    input wire logic       i_ref_clk,
    input wire logic       i_nrst,
    input wire logic       i_vbus,
    input wire logic       i_bus_activity,
    input wire logic [6:0] i_tok_addr,
    input wire logic       i_hs_capable,
    input wire logic       i_self_powered,
    input wire logic [2:0] o_state,
    input wire logic       o_suspended,
    input wire logic       o_in_reset,
    input wire logic       o_tok_match,
    input wire logic [6:0] o_dev_addr,
    input wire logic [7:0] o_cfg_val,
    input wire logic       o_self_powered,
    input wire logic       o_high_speed,
    input wire logic       o_rwake_en,
    input wire logic       o_ep_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    property p_early; o_tok_match |-> $past(o_state) >= 3'h2 && !$past(o_suspended); endproperty
    a_early: assert property (p_early) else $error("token answered early");
    property p_match; o_tok_match |-> $past(i_tok_addr) == $past(o_dev_addr); endproperty
    a_match: assert property (p_match) else $error("token address mismatch");
    property p_dflt;
        $fell(o_in_reset) |-> o_state == 3'h2 && o_dev_addr == 7'h00 && o_cfg_val == 8'h00;
    endproperty
    a_dflt: assert property (p_dflt) else $error("reset end not default");
    property p_rwk; o_in_reset |=> !o_rwake_en; endproperty
    a_rwk: assert property (p_rwk) else $error("wakeup enable kept in reset");
    property p_epr; o_ep_reset |-> o_state == 3'h4 && o_cfg_val != 8'h00; endproperty
    a_epr: assert property (p_epr) else $error("endpoint reset without config");
    property p_keep; $rose(o_suspended) |-> $stable(o_dev_addr) && $stable(o_cfg_val); endproperty
    a_keep: assert property (p_keep) else $error("state lost at suspend");
    property p_vbus; !i_vbus [*4] |-> o_state == 3'h0; endproperty
    a_vbus: assert property (p_vbus) else $error("powered without supply");
    property p_src; i_self_powered [*4] |-> o_self_powered; endproperty
    a_src: assert property (p_src) else $error("power source not shown");
    property p_hs; $rose(o_high_speed) |-> i_hs_capable; endproperty
    a_hs: assert property (p_hs) else $error("high speed without strap");
    property p_wake; i_bus_activity |-> ##3 !o_suspended; endproperty
    a_wake: assert property (p_wake) else $error("no wake on activity");
endmodule : udst_tracker_chk
bind udst_tracker udst_tracker_chk u_chk (.*);

//--- test/tb.sv
// self-checking bench for the device state tracker
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %0t %s", $time, msg); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_attached = 1'b0, i_vbus = 1'b0;
    logic i_hs_chirp_ok = 1'b0, i_self_powered = 1'b1, i_hs_capable = 1'b1;
    logic i_tok_valid = 1'b0, i_set_cfg = 1'b0, i_cfg_one_mode = 1'b0;
    logic i_cfg_high_power = 1'b0, i_set_rwake = 1'b0, i_clr_rwake = 1'b0, quiet = 1'b0;
    logic i_bus_reset, i_bus_activity, i_set_addr;
    logic [6:0] i_tok_addr = 7'h7f, i_set_addr_val, o_dev_addr, dev_a;
    logic [7:0] i_set_cfg_val = 8'h00, o_cfg_val;
    logic [2:0] o_state;
    logic o_suspended, o_in_reset, o_tok_match, o_self_powered, o_high_speed;
    logic o_rwake_en, o_ep_reset;
    int err_total = 0, checked = 0, cycles = 0;
    udst_tracker #(.IDLE_CYC(20'h00032)) i_dut (.*);
    udst_host_model u_host (.i_ref_clk(i_ref_clk), .i_quiet(quiet), .o_bus_reset(i_bus_reset),
        .o_activity(i_bus_activity), .o_set_addr(i_set_addr), .o_addr_val(i_set_addr_val));
    always #2.5 i_ref_clk = ~i_ref_clk;
    task automatic finish_test();
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            finish_test();
        end
    end
    task automatic step(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : step
    task automatic tok(input logic [6:0] a, input logic exp);
        @(negedge i_ref_clk);
        i_tok_valid = 1'b1;
        i_tok_addr = a;
        @(negedge i_ref_clk);
        i_tok_valid = 1'b0;
        i_tok_addr = ~a;
        `CHK(o_tok_match, exp, "token answer")
    endtask : tok
    task automatic cfg(input logic [7:0] v);
        @(negedge i_ref_clk);
        i_set_cfg = 1'b1;
        i_set_cfg_val = v;
        @(negedge i_ref_clk);
        i_set_cfg = 1'b0;
        `CHK(o_ep_reset, 1'b1, "endpoint reset")
        `CHK(o_state, 3'h4, "configured")
    endtask : cfg
    task automatic t_power();
        i_attached = 1'b1;
        step(5);
        `CHK(o_state, 3'h0, "powered without supply")
        i_vbus = 1'b1;
        step(5);
        `CHK(o_state, 3'h1, "not powered")
        tok(7'h00, 1'b0);
        u_host.assign_addr(dev_a);
        `CHK(o_dev_addr, 7'h00, "address taken before reset")
    endtask : t_power
    task automatic t_reset(input logic chirp, input logic cap);
        i_hs_chirp_ok = chirp;
        i_hs_capable = cap;
        fork
            u_host.drive_reset(10);
            begin step(6); `CHK(o_in_reset, 1'b1, "reset unseen") end
        join
        step(4);
        `CHK(o_state, 3'h2, "not default")
        `CHK(o_dev_addr, 7'h00, "address kept")
        `CHK(o_high_speed, chirp & cap, "speed choice")
        `CHK(o_rwake_en, 1'b0, "wakeup kept")
        tok(7'h00, 1'b1);
        i_set_cfg = 1'b1;
        i_set_cfg_val = 8'h01;
        step(1);
        i_set_cfg = 1'b0;
        `CHK(o_ep_reset, 1'b0, "configured from default")
        `CHK(o_cfg_val, 8'h00, "config taken in default")
    endtask : t_reset
    task automatic t_addr();
        logic [6:0] late_a;
        u_host.assign_addr(dev_a);
        `CHK(o_state, 3'h3, "not address state")
        `CHK(o_dev_addr, dev_a, "address wrong")
        tok(dev_a, 1'b1);
        i_set_rwake = 1'b1;
        step(1);
        i_set_rwake = 1'b0;
        `CHK(o_rwake_en, 1'b1, "wakeup not set")
        i_clr_rwake = 1'b1;
        step(1);
        `CHK(o_rwake_en, 1'b0, "wakeup not cleared")
        i_set_rwake = 1'b1;
        step(1);
        i_set_rwake = 1'b0;
        i_clr_rwake = 1'b0;
        `CHK(o_rwake_en, 1'b1, "wakeup set lost to clear")
        cfg(8'h01);
        u_host.assign_addr(late_a);
        `CHK(o_dev_addr, dev_a, "address changed while configured")
        `CHK(o_state, 3'h4, "configuration lost to address")
    endtask : t_addr
    task automatic t_source();
        i_cfg_high_power = 1'b1;
        i_self_powered = 1'b0;
        step(5);
        `CHK(o_self_powered, 1'b0, "source bit")
        `CHK(o_state, 3'h3, "heavy config kept")
        i_cfg_high_power = 1'b0;
        cfg(8'h02);
        i_cfg_one_mode = 1'b1;
        i_self_powered = 1'b1;
        step(5);
        `CHK(o_cfg_val, 8'h00, "one-mode config kept")
        `CHK(o_self_powered, 1'b1, "source bit")
        i_cfg_one_mode = 1'b0;
        cfg(8'h03);
    endtask : t_source
    task automatic t_suspend();
        quiet = 1'b1;
        step(80);
        `CHK(o_suspended, 1'b1, "no suspend")
        `CHK(o_dev_addr, dev_a, "address lost")
        `CHK(o_cfg_val, 8'h03, "config lost")
        tok(dev_a, 1'b0);
        quiet = 1'b0;
        step(20);
        `CHK(o_suspended, 1'b0, "no resume")
        `CHK(o_state, 3'h4, "wrong resume state")
    endtask : t_suspend
    task automatic t_unplug();
        i_vbus = 1'b0;
        step(5);
        `CHK(o_state, 3'h0, "state kept without supply")
        `CHK(o_cfg_val, 8'h00, "config kept without supply")
        `CHK(o_dev_addr, 7'h00, "address kept without supply")
        `CHK(o_rwake_en, 1'b0, "wakeup kept without supply")
        i_vbus = 1'b1;
        step(5);
        `CHK(o_state, 3'h1, "not powered again")
        tok(7'h00, 1'b0);
    endtask : t_unplug
    initial
    begin
        step(6);
        i_nrst = 1'b1;
        t_power();
        t_reset(1'b1, 1'b1);
        t_addr();
        t_source();
        t_suspend();
        t_reset(1'b0, 1'b1);
        t_addr();
        t_unplug();
        t_reset(1'b1, 1'b0);
        finish_test();
    end
endmodule : tb
